// ==== logic/device_option_word_decoder.sv ====
// option word programming access, decode and reset/sleep sequencing
//
// Overview of operation
// - programmed option bit reads 0, unprogrammed reads 1; erased word is all ones
// - option word lives at 2007h inside configuration space 2000h to 3FFFh
// - configuration space is reachable only in programming mode
// - protect pair: 11 none, 10 upper half, 01 upper 3/4, 00 all
// - unimplemented bit always reads back as 1
// - bit 6 set enables brown-out reset, clear disables it
// - bit 3 clear enables power-up delay, set disables it
// - bit 2 set runs watchdog, clear stops it
// - oscillator bits: 11 resistor-capacitor, 10 high-speed, 01 crystal, 00 low-power
// - brown-out reset enabled forces power-up delay on regardless of bit 3
// - power-up delay holds reset a fixed nominal 72 ms, after power-up only
// - watchdog can be turned off only by the option word
// - oscillator start-up wait holds reset until crystal is stable
// - sleep ends on external reset, watchdog wake-up or interrupt
`timescale 1ns/1ps
module device_option_word_decoder #(
    parameter int DELAY_CYCLES = option_word_pkg::POWER_UP_DELAY_CYCLES
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic prog_mode_pin,
    input option_word_pkg::prog_req_s prog_req,
    input wire logic prog_erase,
    output logic [option_word_pkg::WORD_W-1:0] prog_rdata,
    output logic prog_rvalid,
    output logic prog_refused,
    input wire logic ext_reset_n_pin,
    input wire logic brownout_pin,
    input wire logic osc_stable_pin,
    input wire logic sleep_request,
    input wire logic watchdog_wake,
    input wire logic irq_wake,
    output option_word_pkg::option_cfg_s cfg,
    output logic cfg_valid,
    output logic device_in_reset,
    output logic device_sleeping,
    output logic watchdog_run
);

    localparam int CNT_W = $clog2(DELAY_CYCLES + 1);
    localparam logic [CNT_W-1:0] DELAY_LAST = CNT_W'(DELAY_CYCLES - 1);

    typedef enum logic [2:0] {
        st_load,
        st_osc_wait,
        st_power_delay,
        st_run,
        st_sleep
    } seq_state_e;

    function automatic option_word_pkg::option_cfg_s decode_word(
        input logic [option_word_pkg::WORD_W-1:0] w
    );
        logic [1:0] all_and;
        logic [1:0] all_or;
        option_word_pkg::option_cfg_s c;
        all_and = 2'h3;
        all_or = 2'h0;
        for (int i = 0; i < option_word_pkg::PROTECT_COPIES; i++) begin
            all_and = all_and & w[option_word_pkg::PROTECT_LSB[i] +: 2];
            all_or = all_or | w[option_word_pkg::PROTECT_LSB[i] +: 2];
        end
        // copies that disagree: a zero in any copy wins, the stronger protection
        c.protect = option_word_pkg::protect_e'(all_and);
        c.protect_mismatch = (all_and != all_or);
        c.brownout_reset_enable = w[option_word_pkg::BIT_BROWNOUT];
        c.power_up_delay_active = !w[option_word_pkg::BIT_DELAY_N]
            || w[option_word_pkg::BIT_BROWNOUT];
        c.watchdog_enable = w[option_word_pkg::BIT_WATCHDOG];
        c.osc_mode = option_word_pkg::osc_mode_e'(w[option_word_pkg::OSC_LSB +: 2]);
        return c;
    endfunction

    // pin synchronisers
    logic [option_word_pkg::PIN_COUNT-1:0] pin_raw;
    logic [option_word_pkg::PIN_COUNT-1:0] pin_meta;
    logic [option_word_pkg::PIN_COUNT-1:0] pin_sync;

    assign pin_raw = {osc_stable_pin, brownout_pin, ext_reset_n_pin, prog_mode_pin};

    for (genvar g = 0; g < option_word_pkg::PIN_COUNT; g++) begin : g_sync
        always_ff @(posedge clk_sys) begin
            if (!resetn) begin
                pin_meta[g] <= option_word_pkg::PIN_IDLE[g];
                pin_sync[g] <= option_word_pkg::PIN_IDLE[g];
            end else if (ce) begin
                pin_meta[g] <= pin_raw[g];
                pin_sync[g] <= pin_meta[g];
            end
        end
    end

    logic prog_mode;
    logic ext_reset_n;
    logic brownout_low;
    logic osc_stable;

    assign prog_mode = pin_sync[option_word_pkg::PIN_PROG_MODE];
    assign ext_reset_n = pin_sync[option_word_pkg::PIN_EXT_RESET_N];
    assign brownout_low = pin_sync[option_word_pkg::PIN_BROWNOUT];
    assign osc_stable = pin_sync[option_word_pkg::PIN_OSC_STABLE];

    // programming access
    logic in_space;
    logic take_write;
    logic take_read;
    logic [option_word_pkg::WORD_W-1:0] store_rdata;

    assign in_space = (prog_req.addr >= option_word_pkg::CFG_SPACE_LO)
        && (prog_req.addr <= option_word_pkg::CFG_SPACE_HI);
    assign take_write = prog_req.write && prog_mode && in_space;
    assign take_read = prog_req.read && prog_mode && in_space;

    option_word_store #(
        .WIDTH(option_word_pkg::WORD_W)
    ) u_store (
        .clk_sys(clk_sys),
        .ce(ce),
        .erase(prog_erase && prog_mode),
        .wr_en(take_write && (prog_req.addr == option_word_pkg::OPTION_ADDR)),
        .wdata(prog_req.wdata),
        .rdata(store_rdata)
    );

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            prog_rdata <= option_word_pkg::ERASED_WORD;
            prog_rvalid <= 1'b0;
            prog_refused <= 1'b0;
        end else if (ce) begin
            prog_rvalid <= take_read;
            // a refused access leaves the store untouched and answers no data
            prog_refused <= (prog_req.write || prog_req.read) && !(prog_mode && in_space);
            if (take_read) begin
                // other test-space words read as erased
                prog_rdata <= (prog_req.addr == option_word_pkg::OPTION_ADDR)
                    ? store_rdata : option_word_pkg::ERASED_WORD;
            end
        end
    end

    // reset and sleep sequencing
    seq_state_e state;
    logic load_step;
    logic power_up_pending;
    logic [CNT_W-1:0] delay_cnt;
    logic brownout_trip;
    logic hold_request;

    assign brownout_trip = brownout_low && cfg_valid && cfg.brownout_reset_enable;
    // programming mode holds the core in reset as well
    assign hold_request = prog_mode || !ext_reset_n || brownout_trip;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state <= st_load;
            load_step <= 1'b0;
        end else if (ce) begin
            if (hold_request) begin
                state <= st_load;
                load_step <= 1'b0;
            end else begin
                unique case (state)
                    st_load: begin
                        // first cycle lets the store read register settle
                        load_step <= 1'b1;
                        if (load_step) begin
                            state <= st_osc_wait;
                        end
                    end
                    st_osc_wait: begin
                        if (cfg.osc_mode == option_word_pkg::resistor_capacitor_mode
                                || osc_stable) begin
                            if (power_up_pending && cfg.power_up_delay_active) begin
                                state <= st_power_delay;
                            end else begin
                                state <= st_run;
                            end
                        end
                    end
                    st_power_delay: begin
                        if (delay_cnt == DELAY_LAST) begin
                            state <= st_run;
                        end
                    end
                    st_run: begin
                        if (sleep_request) begin
                            state <= st_sleep;
                        end
                    end
                    st_sleep: begin
                        if (irq_wake || (watchdog_wake && watchdog_run)) begin
                            state <= st_osc_wait;
                        end
                    end
                    default: begin
                        state <= st_load;
                    end
                endcase
            end
        end
    end

    // only power-on and brown-out count as power-up
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            power_up_pending <= 1'b1;
        end else if (ce) begin
            if (brownout_trip) begin
                power_up_pending <= 1'b1;
            end else if (state == st_run) begin
                power_up_pending <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            delay_cnt <= '0;
        end else if (ce) begin
            if (state == st_power_delay && !hold_request) begin
                delay_cnt <= delay_cnt + CNT_W'(1);
            end else begin
                delay_cnt <= '0;
            end
        end
    end

    // capture once per reset; no other path alters the decoded values
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cfg <= decode_word(option_word_pkg::ERASED_WORD);
            cfg_valid <= 1'b0;
        end else if (ce) begin
            if (state == st_load && !hold_request && load_step) begin
                cfg <= decode_word(store_rdata);
                cfg_valid <= 1'b1;
            end else if (state == st_load && !load_step) begin
                cfg_valid <= 1'b0;
            end
        end
    end

    assign device_in_reset = (state == st_load) || (state == st_osc_wait)
        || (state == st_power_delay);
    assign device_sleeping = (state == st_sleep);
    assign watchdog_run = cfg_valid && cfg.watchdog_enable;

    // checks
    property p_unimpl_one;
        @(posedge clk_sys) disable iff (!resetn)
        prog_rvalid |-> prog_rdata[option_word_pkg::BIT_UNIMPL];
    endproperty
    a_unimpl_one: assert property (p_unimpl_one) else $error("unimplemented bit read as 0");

    property p_refuse_outside_prog;
        @(posedge clk_sys) disable iff (!resetn)
        ce && prog_req.read && !prog_mode |=> prog_refused && !prog_rvalid;
    endproperty
    a_refuse_outside_prog: assert property (p_refuse_outside_prog) else $error("access taken outside programming");

    property p_cfg_held;
        @(posedge clk_sys) disable iff (!resetn)
        state != st_load && $past(state) != st_load |-> $stable(cfg);
    endproperty
    a_cfg_held: assert property (p_cfg_held) else $error("decoded option changed outside reset");

    property p_brownout_forces_delay;
        @(posedge clk_sys) disable iff (!resetn)
        cfg_valid && cfg.brownout_reset_enable |-> cfg.power_up_delay_active;
    endproperty
    a_brownout_forces_delay: assert property (p_brownout_forces_delay) else $error("power-up delay not forced");

    property p_watchdog_cannot_wake_when_off;
        @(posedge clk_sys) disable iff (!resetn)
        ce && state == st_sleep && !cfg.watchdog_enable && watchdog_wake && !irq_wake
            && !hold_request |=> state == st_sleep;
    endproperty
    a_watchdog_cannot_wake_when_off: assert property (p_watchdog_cannot_wake_when_off) else $error("disabled watchdog woke device");

    property p_osc_wait_holds;
        @(posedge clk_sys) disable iff (!resetn)
        ce && state == st_osc_wait && !osc_stable
            && cfg.osc_mode != option_word_pkg::resistor_capacitor_mode |=> device_in_reset;
    endproperty
    a_osc_wait_holds: assert property (p_osc_wait_holds) else $error("left reset before oscillator stable");

    property p_delay_full_length;
        @(posedge clk_sys) disable iff (!resetn)
        state == st_run && $past(state) == st_power_delay |-> $past(delay_cnt) == DELAY_LAST;
    endproperty
    a_delay_full_length: assert property (p_delay_full_length) else $error("power-up delay cut short");

    property p_irq_wakes;
        @(posedge clk_sys) disable iff (!resetn)
        ce && state == st_sleep && irq_wake && !hold_request |=> state == st_osc_wait;
    endproperty
    a_irq_wakes: assert property (p_irq_wakes) else $error("interrupt did not end sleep");

    c_reach_run: cover property (@(posedge clk_sys) disable iff (!resetn) state == st_run);
    c_power_delay: cover property (@(posedge clk_sys) disable iff (!resetn)
        state == st_power_delay ##1 state == st_run);
    c_sleep_wake: cover property (@(posedge clk_sys) disable iff (!resetn)
        state == st_sleep ##1 state == st_osc_wait);
    c_prog_read: cover property (@(posedge clk_sys) disable iff (!resetn) prog_rvalid);

endmodule // device_option_word_decoder

// ==== logic/option_word_pkg.sv ====
// constants, field layout and types shared by the option word decoder and its store
package option_word_pkg;

    localparam int WORD_W = 14;
    localparam int ADDR_W = 14;

    // programming address space
    localparam logic [ADDR_W-1:0] OPTION_ADDR = 14'h2007;
    localparam logic [ADDR_W-1:0] CFG_SPACE_LO = 14'h2000;
    localparam logic [ADDR_W-1:0] CFG_SPACE_HI = 14'h3FFF;

    // an unprogrammed bit reads as one, so the erased word is all ones
    localparam logic [WORD_W-1:0] ERASED_WORD = 14'h3FFF;

    // field positions
    localparam int BIT_UNIMPL = 7;
    localparam int BIT_BROWNOUT = 6;
    localparam int BIT_DELAY_N = 3;
    localparam int BIT_WATCHDOG = 2;
    localparam int OSC_LSB = 0;
    localparam int PROTECT_COPIES = 4;
    localparam int PROTECT_LSB [PROTECT_COPIES] = '{12, 10, 8, 4};
    localparam logic [WORD_W-1:0] UNIMPL_MASK = 14'h0080;

    // power-up delay: nominal time and derived cycle count
    localparam int POWER_UP_DELAY_MS = 72;
    localparam int CLK_PERIOD_NS = 8;
    localparam int NS_PER_MS = 1000000;
    localparam int POWER_UP_DELAY_CYCLES = POWER_UP_DELAY_MS * NS_PER_MS / CLK_PERIOD_NS;

    // pin synchroniser positions
    localparam int PIN_COUNT = 4;
    localparam int PIN_PROG_MODE = 0;
    localparam int PIN_EXT_RESET_N = 1;
    localparam int PIN_BROWNOUT = 2;
    localparam int PIN_OSC_STABLE = 3;
    localparam logic [PIN_COUNT-1:0] PIN_IDLE = 4'h2;

    // declaration order gives the field encodings 00, 01, 10, 11
    typedef enum logic [1:0] {
        low_power_crystal_mode,
        crystal_resonator_mode,
        high_speed_crystal_mode,
        resistor_capacitor_mode
    } osc_mode_e;

    typedef enum logic [1:0] {
        protect_all,
        protect_upper_3q,
        protect_upper_half,
        protect_none
    } protect_e;

    typedef struct packed {
        protect_e protect;
        logic protect_mismatch;
        logic brownout_reset_enable;
        logic power_up_delay_active;
        logic watchdog_enable;
        osc_mode_e osc_mode;
    } option_cfg_s;

    typedef struct packed {
        logic write;
        logic read;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } prog_req_s;

endpackage

// ==== logic/option_word_store.sv ====
// non-volatile option word cell with registered read data
`timescale 1ns/1ps
module option_word_store #(
    parameter int WIDTH = option_word_pkg::WORD_W
) (
    input wire logic clk_sys,
    input wire logic ce,
    input wire logic erase,
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] word;

    // no reset: contents survive device resets, like the real cell
    always_ff @(posedge clk_sys) begin
        if (ce) begin
            if (erase) begin
                word <= option_word_pkg::ERASED_WORD;
            end else if (wr_en) begin
                // programming can only pull bits to zero
                word <= word & wdata;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (ce) begin
            rdata <= word | option_word_pkg::UNIMPL_MASK;
        end
    end

endmodule // option_word_store

// ==== test/option_programmer.sv ====
// programmer model for the option word programming port
`timescale 1ns/1ps
module option_programmer (
    input wire logic clk_sys,
    input wire logic [option_word_pkg::WORD_W-1:0] prog_rdata,
    input wire logic prog_rvalid,
    input wire logic prog_refused,
    output option_word_pkg::prog_req_s prog_req,
    output logic prog_erase,
    output logic prog_mode_pin
);
    initial begin
        prog_req = '0;
        prog_erase = 1'b0;
        prog_mode_pin = 1'b0;
    end
    // settle past the pin synchroniser before any request
    task automatic set_mode(input logic on);
        @(posedge clk_sys);
        #1 prog_mode_pin = on;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic access(input logic wr, input logic [13:0] addr, input logic [13:0] wdata,
                          output logic [13:0] rd, output logic rv, output logic rf);
        @(posedge clk_sys);
        #1 prog_req = {wr, !wr, addr, wdata};
        @(posedge clk_sys);
        #1 rd = prog_rdata;
        rv = prog_rvalid;
        rf = prog_refused;
        // released fields must not keep showing the last value
        prog_req = {2'b00, ~addr, ~wdata};
    endtask
    task automatic erase();
        @(posedge clk_sys);
        #1 prog_erase = 1'b1;
        @(posedge clk_sys);
        #1 prog_erase = 1'b0;
    endtask
    // flags: unimplemented, brown-out, delay disable, watchdog
    task automatic write_word(input logic [1:0] prot, input logic [3:0] flags,
                           input logic [1:0] osc, output logic [13:0] w);
        logic [13:0] rd;
        logic rv, rf;
        w = {prot, prot, prot, flags[3], flags[2], prot, flags[1], flags[0], osc};
        access(1'b1, 14'h2007, w, rd, rv, rf);
    endtask
endmodule // option_programmer

// ==== test/tb.sv ====
// self-checking bench for the option word decoder
`timescale 1ns/1ps
module tb;
    localparam int DELAY = 16;
    logic clk_sys, resetn, ext_reset_n_pin, brownout_pin, osc_stable_pin;
    logic sleep_request, watchdog_wake, irq_wake, prog_erase, prog_mode_pin, ce;
    logic prog_rvalid, prog_refused, cfg_valid, device_in_reset, device_sleeping, watchdog_run;
    logic [13:0] prog_rdata, rd, w;
    logic [13:0] exp_q[$];
    logic rv, rf;
    logic [3:0] r;
    option_word_pkg::prog_req_s prog_req;
    option_word_pkg::option_cfg_s cfg;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int n;

    device_option_word_decoder #(.DELAY_CYCLES(DELAY)) dut (
        .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .prog_mode_pin(prog_mode_pin),
        .prog_req(prog_req), .prog_erase(prog_erase), .prog_rdata(prog_rdata),
        .prog_rvalid(prog_rvalid), .prog_refused(prog_refused),
        .ext_reset_n_pin(ext_reset_n_pin), .brownout_pin(brownout_pin),
        .osc_stable_pin(osc_stable_pin), .sleep_request(sleep_request),
        .watchdog_wake(watchdog_wake), .irq_wake(irq_wake), .cfg(cfg), .cfg_valid(cfg_valid),
        .device_in_reset(device_in_reset), .device_sleeping(device_sleeping),
        .watchdog_run(watchdog_run)
    );
    option_programmer prg (
        .clk_sys(clk_sys), .prog_rdata(prog_rdata), .prog_rvalid(prog_rvalid),
        .prog_refused(prog_refused), .prog_req(prog_req), .prog_erase(prog_erase),
        .prog_mode_pin(prog_mode_pin)
    );

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            $display("[ERR] %0t timeout", $time);
            conclude();
        end
    end

    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    // cycles until the core leaves reset, bounded
    task automatic wait_run(input int lim, output int cnt);
        cnt = 0;
        while (device_in_reset !== 1'b0 && cnt < lim) begin
            @(posedge clk_sys);
            #1 cnt++;
        end
    endtask

    function automatic option_word_pkg::option_cfg_s exp_decode(input logic [13:0] v);
        option_word_pkg::option_cfg_s e;
        // differing protect copies combine bitwise, a zero in any copy wins
        e.protect = option_word_pkg::protect_e'(v[13:12] & v[11:10] & v[9:8] & v[5:4]);
        e.protect_mismatch = !(v[13:12] == v[5:4] && v[11:10] == v[5:4] && v[9:8] == v[5:4]);
        e.brownout_reset_enable = v[6];
        e.power_up_delay_active = v[6] | !v[3];
        e.watchdog_enable = v[2];
        e.osc_mode = option_word_pkg::osc_mode_e'(v[1:0]);
        return e;
    endfunction

    task automatic pulse(ref logic s);
        @(posedge clk_sys);
        #1 s = 1'b1;
        @(posedge clk_sys);
        #1 s = 1'b0;
    endtask

    initial begin
        n = $urandom(40);
        resetn = 1'b0;
        ce = 1'b1;
        ext_reset_n_pin = 1'b1;
        brownout_pin = 1'b0;
        osc_stable_pin = 1'b0;
        sleep_request = 1'b0;
        watchdog_wake = 1'b0;
        irq_wake = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 resetn = 1'b1;
        prg.access(1'b0, 14'h2007, 14'h0000, rd, rv, rf);
        check(rf === 1'b1 && rv === 1'b0, "read outside programming mode answered");
        $display("test refusal done");
        for (int i = 0; i < 4; i++) begin
            r = 4'($urandom);
            osc_stable_pin = 1'b0;
            prg.set_mode(1'b1);
            prg.erase();
            prg.access(1'b0, 14'h2007, 14'h0000, rd, rv, rf);
            check(rv === 1'b1 && rd === 14'h3FFF, "erased word not all ones");
            prg.access(1'b0, 14'h1FFF, 14'h0000, rd, rv, rf);
            check(rf === 1'b1 && rv === 1'b0, "address below space accepted");
            prg.write_word(2'(i), {r[3], (i == 3) || r[0], r[1], r[2]}, 2'(i), w);
            prg.access(1'b1, 14'h2006, 14'h0000, rd, rv, rf);
            exp_q.push_back(w | 14'h0080);
            prg.access(1'b0, 14'h2007, 14'h0000, rd, rv, rf);
            check(rv === 1'b1 && rd === exp_q.pop_front(), "option word read back");
            prg.access(1'b0, 14'h3000, 14'h0000, rd, rv, rf);
            check(rd === 14'h3FFF, "other configuration word");
            prg.set_mode(1'b0);
            n = 0;
            while (cfg_valid !== 1'b1 && n < 10) begin
                @(posedge clk_sys);
                #1 n++;
            end
            check(cfg_valid === 1'b1 && cfg === exp_decode(w | 14'h0080),
                  "decoded options");
            check(watchdog_run === w[2], "watchdog run");
            if (w[1:0] != 2'b11) begin
                repeat (8) @(posedge clk_sys);
                #1;
                check(device_in_reset === 1'b1, "left reset before oscillator stable");
                osc_stable_pin = 1'b1;
            end
            wait_run(60, n);
            check(n < 60, "core never left reset");
            prg.access(1'b1, 14'h2007, 14'h0000, rd, rv, rf);
            check(rf === 1'b1 && cfg === exp_decode(w | 14'h0080), "run-time write");
            pulse(sleep_request);
            check(device_sleeping === 1'b1, "sleep not entered");
            pulse(watchdog_wake);
            repeat (2) @(posedge clk_sys);
            #1 check(device_sleeping === !w[2], "watchdog wake-up");
            pulse(irq_wake);
            wait_run(20, n);
            check(device_sleeping === 1'b0 && n < 20, "interrupt wake-up");
            $display("test option set %0d done", i);
        end
        // last set enables brown-out reset, which forces the power-up delay on
        @(posedge clk_sys);
        #1 resetn = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 resetn = 1'b1;
        wait_run(60, n);
        check(n >= DELAY && n <= DELAY + 8, "power-up delay length");
        @(posedge clk_sys);
        #1 ext_reset_n_pin = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 ext_reset_n_pin = 1'b1;
        wait_run(60, n);
        check(n > 0 && n < DELAY, "delay ran after external reset");
        @(posedge clk_sys);
        #1 brownout_pin = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 check(device_in_reset === 1'b1, "brown-out did not reset");
        brownout_pin = 1'b0;
        wait_run(60, n);
        check(n >= DELAY && n <= DELAY + 8, "power-up delay after brown-out");
        $display("test reset timing done");
        // frozen clock enable must keep the core out of sleep
        ce = 1'b0;
        pulse(sleep_request);
        check(device_sleeping === 1'b0 && cfg_valid === 1'b1, "state moved with ce low");
        ce = 1'b1;
        $display("test clock enable done");
        conclude();
    end
endmodule // tb
